// ---- core/lsr_pkg.sv ----
// Behaviour
// RULE1 - Each element is a 16-stage delay line
// RULE2 - Shift on rising edge while enable high; the code also holds the shift while the capture FIFO is full
// RULE3 - Four-bit tap picks any stored stage
// RULE4 - Last stage always on its own output
// RULE5 - Cascade output and shift enable provided
// RULE6 - Upper element feeds lower through cascade mux
// RULE7 - Chain lines join slice to slice below
// RULE8 - Four elements chained give 64 cycles
// RULE9 - User may chain across several clusters
// RULE10 - User may add one register after tap
// RULE11 - Stages have no reset or preset
// RULE12 - Elements share one clock and enable
// RULE13 - Unused shift enable counts as asserted
// RULE14 - Tap n delays by n+1 enabled edges
package lsr_pkg;

  // ==========================================================
  // Geometry
  localparam int LSR_STAGES     = 16;
  localparam int LSR_TAP_W      = 4;
  localparam int LSR_ELEMS      = 4;
  localparam int LSR_FIFO_DEPTH = 8;

  // ==========================================================
  // Register bus
  localparam int          LSR_ADDR_W   = 4;
  localparam int          LSR_DATA_W   = 32;
  localparam logic [3:0]  LSR_OFF_CTRL   = 4'h0;
  localparam logic [3:0]  LSR_OFF_STATUS = 4'h4;
  localparam logic [3:0]  LSR_OFF_STAGES = 4'h8;
  localparam logic [3:0]  LSR_OFF_TAP    = 4'hc;

  // ==========================================================
  // Field layout
  localparam int LSR_CTRL_EN_USED_BIT  = 0;
  localparam int LSR_CTRL_CHAIN_LSB    = 8;
  localparam int LSR_STAT_LAST_LSB     = 0;
  localparam int LSR_STAT_FILL_LSB     = 8;
  localparam int LSR_STAT_FULL_BIT     = 16;
  localparam int LSR_STAT_VALID_BIT    = 17;
  localparam int LSR_STAGES_HI_LSB     = 16;

  // ==========================================================
  // Reset values
  localparam logic       LSR_EN_USED_RST = 1'b0;
  localparam logic [3:0] LSR_CHAIN_RST   = 4'he;

endpackage : lsr_pkg

// ---- core/lsr_fifo.sv ----
// ==========================================================
// Collapsing FIFO: head always sits in entry 0, so the read
// side is a plain flip-flop at the cost of moving every entry
module lsr_fifo
  import lsr_pkg::*;
#(
  parameter int W     = 4,
  parameter int DEPTH = 8,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          en,
  input  wire logic          in_valid,
  input  wire logic [W-1:0]  in_data,
  output logic               in_ready,
  output logic               out_valid,
  output logic [W-1:0]       out_data,
  input  wire logic          out_ready,
  output logic [CW-1:0]      fill
);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          full_ff;
  logic          valid_ff;
  logic          push;
  logic          pop;

  assign push      = in_valid & ~full_ff;
  assign pop       = valid_ff & out_ready;
  assign in_ready  = ~full_ff;
  assign out_valid = valid_ff;
  assign out_data  = mem_ff[0];
  assign fill      = cnt_ff;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff   <= '0;
      full_ff  <= 1'b0;
      valid_ff <= 1'b0;
    end else if (en) begin
      cnt_ff   <= nxt_cnt;
      full_ff  <= (nxt_cnt == CW'(DEPTH));
      valid_ff <= (nxt_cnt != '0);
    end
  end

  // Entries carry data only, so they need no reset
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk) begin
      if (en) begin
        if (pop) begin
          if (push && (cnt_ff == CW'(i + 1))) begin
            mem_ff[i] <= in_data;
          end else if (i < DEPTH - 1) begin
            mem_ff[i] <= mem_ff[(i < DEPTH - 1) ? i + 1 : i];
          end
        end else if (push && (cnt_ff == CW'(i))) begin
          mem_ff[i] <= in_data;
        end
      end
    end
  end

endmodule // lsr_fifo

// ---- core/lsr_delay_line.sv ----
// ==========================================================
// Delay line cluster
// Elements in pairs form slices: even index is the upper
// element, odd index the lower one. Element 0 can take the
// chain line from the slice above; the last element drives
// the chain line to the slice below.
//
// Added by the designer: the address map and register access over Avalon-MM.
module lsr_delay_line
  import lsr_pkg::*;
#(
  parameter int ELEMS = LSR_ELEMS,
  parameter int DEPTH = LSR_FIFO_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    en,

  input  wire logic                    serial_in,
  input  wire logic                    chain_in,
  input  wire logic                    shift_en,
  input  wire logic [ELEMS*LSR_TAP_W-1:0] tap_addr,

  output logic [ELEMS-1:0]             tap_out,
  output logic [ELEMS-1:0]             last_stage_out,
  output logic                         chain_out,

  output logic                         tap_valid,
  output logic [ELEMS-1:0]             tap_data,
  input  wire logic                    tap_ready,

  input  wire logic [LSR_ADDR_W-1:0]   avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [LSR_DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [LSR_DATA_W-1:0]        avs_readdata,
  output logic                         avs_waitrequest
);

  // ==========================================================
  // Declarations
  logic [LSR_STAGES-1:0]   stage_ff   [ELEMS];
  logic [LSR_STAGES-1:0]   nxt_stage  [ELEMS];
  logic [ELEMS-1:0]        in_bit;
  logic [ELEMS-1:0]        cascade_out;
  logic [ELEMS-1:0]        nxt_tap;
  logic [ELEMS-1:0]        tap_ff;

  logic                    en_used_ff;
  logic [ELEMS-1:0]        chain_sel_ff;

  logic                    wait_ff;
  logic [LSR_DATA_W-1:0]   rdata_ff;
  logic [LSR_DATA_W-1:0]   nxt_rdata;
  logic                    wr_commit;
  logic                    rd_accept;

  logic                    shift_req;
  logic                    shift_go;
  logic                    fifo_in_ready;
  logic [CW-1:0]           fifo_fill;
  logic                    fifo_valid;
  logic [ELEMS-1:0]        fifo_data;

  // ==========================================================
  // Shift enable
  // A tied-off enable pin reads as active until software
  // declares it in use; this keeps a bare instance shifting
  assign shift_req = shift_en | ~en_used_ff; // see RULE13

  // Shifting waits for room in the capture FIFO so no tap
  // sample is ever dropped; the user sees this as a stall
  assign shift_go = shift_req & fifo_in_ready; // see RULE2

  // ==========================================================
  // Element input selection
  for (genvar e = 0; e < ELEMS; e++) begin : g_in
    if (e == 0) begin : g_first
      // Chain line from the slice above, else fresh serial data
      assign in_bit[e] = chain_sel_ff[e] ? chain_in : serial_in;
    end else if ((e % 2) == 1) begin : g_lower
      // Lower element of a slice fed by its upper neighbour
      assign in_bit[e] = chain_sel_ff[e] ? cascade_out[e-1]
                                         : serial_in; // see RULE6
    end else begin : g_upper
      // Upper element continues the slice above in the cluster
      assign in_bit[e] = chain_sel_ff[e] ? cascade_out[e-1]
                                         : serial_in; // see RULE7
    end
  end

  // ==========================================================
  // Storage stages
  for (genvar e = 0; e < ELEMS; e++) begin : g_elem

    // Next content after one enabled edge
    always_comb begin
      if (shift_go) begin
        nxt_stage[e] = {stage_ff[e][LSR_STAGES-2:0], in_bit[e]};
      end else begin
        nxt_stage[e] = stage_ff[e];
      end
    end

    // No reset term on purpose: content changes only by
    // shifting, exactly like a table element in shift mode
    always_ff @(posedge clk) begin
      if (en && shift_go) begin // see RULE12
        stage_ff[e] <= nxt_stage[e]; // see RULE1 // see RULE11
      end
    end

    // Stage 0 holds the bit from the last enabled edge, so
    // tap n is n+1 edges old; looking at the next content
    // keeps the registered tap in step with the stages
    assign nxt_tap[e] =
      nxt_stage[e][tap_addr[e*LSR_TAP_W +: LSR_TAP_W]]; // see RULE14

    assign cascade_out[e]    = stage_ff[e][LSR_STAGES-1]; // see RULE5
    assign last_stage_out[e] = stage_ff[e][LSR_STAGES-1]; // see RULE4
    assign tap_out[e]        = tap_ff[e];
  end

  // Final element drives the line to the slice below; with
  // all elements chained the line is 64 stages long
  assign chain_out = cascade_out[ELEMS-1]; // see RULE7 // see RULE8

  // ==========================================================
  // Addressable output
  // Registered so the port comes from a flip-flop; a change of
  // tap address shows one clock later
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tap_ff <= '0;
    end else if (en) begin
      tap_ff <= nxt_tap; // see RULE3
    end
  end

  // ==========================================================
  // Tap capture FIFO
  // Every enabled shift pushes the selected taps of all
  // elements, giving a sample stream the user drains
  lsr_fifo #(
    .W     (ELEMS),
    .DEPTH (DEPTH),
    .CW    (CW)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .en        (en),
    .in_valid  (shift_req),
    .in_data   (nxt_tap),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (tap_ready),
    .fill      (fifo_fill)
  );

  assign tap_valid = fifo_valid;
  assign tap_data  = fifo_data;

  // ==========================================================
  // Avalon slave handshake
  // One wait cycle per access: the request is seen with
  // waitrequest high, then waitrequest drops for one cycle; read
  // data is latched as it drops and the write lands as it rises
  assign rd_accept = avs_read & wait_ff;
  assign wr_commit = avs_write & ~wait_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wait_ff <= 1'b1;
    end else if (en) begin
      if ((avs_read || avs_write) && wait_ff) begin
        wait_ff <= 1'b0;
      end else begin
        wait_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read decode
  always_comb begin
    nxt_rdata = '0;
    unique case (avs_address)
      LSR_OFF_CTRL: begin
        nxt_rdata[LSR_CTRL_EN_USED_BIT] = en_used_ff;
        nxt_rdata[LSR_CTRL_CHAIN_LSB +: ELEMS] = chain_sel_ff;
      end
      LSR_OFF_STATUS: begin
        nxt_rdata[LSR_STAT_LAST_LSB +: ELEMS] = last_stage_out;
        nxt_rdata[LSR_STAT_FILL_LSB +: CW]    = fifo_fill;
        nxt_rdata[LSR_STAT_FULL_BIT]          = ~fifo_in_ready;
        nxt_rdata[LSR_STAT_VALID_BIT]         = fifo_valid;
      end
      LSR_OFF_STAGES: begin
        // Live view of the first slice, both elements
        nxt_rdata[LSR_STAGES-1:0] = stage_ff[0];
        nxt_rdata[LSR_STAGES_HI_LSB +: LSR_STAGES] = stage_ff[1];
      end
      LSR_OFF_TAP: begin
        nxt_rdata[ELEMS*LSR_TAP_W-1:0] = tap_addr;
      end
      default: begin
        // Unmapped addresses read as zero
        nxt_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else if (en && rd_accept) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;

  // ==========================================================
  // Control register
  // Writes to other offsets are accepted and ignored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      en_used_ff <= LSR_EN_USED_RST;
    end else if (en && wr_commit && (avs_address == LSR_OFF_CTRL)
                 && avs_byteenable[0]) begin
      en_used_ff <= avs_writedata[LSR_CTRL_EN_USED_BIT]; // see RULE13
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      chain_sel_ff <= ELEMS'(LSR_CHAIN_RST);
    end else if (en && wr_commit && (avs_address == LSR_OFF_CTRL)
                 && avs_byteenable[1]) begin
      chain_sel_ff <= avs_writedata[LSR_CTRL_CHAIN_LSB +: ELEMS];
    end
  end

endmodule // lsr_delay_line

// ---- verif/lsr_monitor.sv ----
// ==========================================================
// Bus, reset and delay line checks
module lsr_monitor
  import lsr_pkg::*;
#(parameter int ELEMS = LSR_ELEMS) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 en,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic                 avs_waitrequest,
  input wire logic [31:0]          avs_readdata,
  input wire logic [ELEMS*4-1:0]   tap_addr,
  input wire logic [ELEMS-1:0]     tap_out,
  input wire logic [ELEMS-1:0]     last_stage_out,
  input wire logic                 chain_out,
  input wire logic                 tap_valid,
  input wire logic [ELEMS-1:0]     tap_data,
  input wire logic                 tap_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Stages are X until 64 shifts, so value checks wait for pops
  logic [6:0] pops_ff;
  always_ff @(posedge clk) begin
    if (!nrst) pops_ff <= 7'h00;
    else if (en && tap_valid && tap_ready && !pops_ff[6])
      pops_ff <= pops_ff + 7'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ans;
    en && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("bus not answered");
  property p_one; en && !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_cause;
    en && !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_cause: assert property (p_cause) else $error("answer unasked");
  property p_rst;
    $rose(nrst) && $past(en) |-> avs_waitrequest && !tap_valid
      && tap_out == '0 && avs_readdata == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_chain;
    pops_ff[6] && en && tap_addr[ELEMS*4-1 -: 4] == 4'hf |=>
      tap_out[ELEMS-1] == chain_out;
  endproperty
  a_chain: assert property (p_chain) else $error("chain out");
  property p_hold;
    pops_ff[6] && !en |=> $stable(last_stage_out) && $stable(tap_out);
  endproperty
  a_hold: assert property (p_hold) else $error("moved frozen");
  property p_tap15;
    pops_ff[6] && en && tap_addr[3:0] == 4'hf |=>
      tap_out[0] == last_stage_out[0];
  endproperty
  a_tap15: assert property (p_tap15) else $error("tap 15");
  property p_keep;
    en && tap_valid && !tap_ready |=> tap_valid && $stable(tap_data);
  endproperty
  a_keep: assert property (p_keep) else $error("head lost");
  c_rd: cover property (avs_read && !avs_waitrequest);
  c_wr: cover property (avs_write && !avs_waitrequest);
  c_stall: cover property (tap_valid && !tap_ready);
endmodule // lsr_monitor

// ---- verif/lsr_user_model.sv ----
// ==========================================================
// User logic: pseudo random serial bits, chain line, drain
module lsr_user_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic stall,
  input wire logic tap_bit,
  output logic     serial_in,
  output logic     chain_in,
  output logic     tap_ready,
  output logic     tap_late
);
  timeunit 1ns;
  timeprecision 1ns;
  // Period 127 keeps every 64-bit window distinct
  logic [6:0] lfsr_ff;
  logic       tap_late_ff;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lfsr_ff <= 7'h01;
    end else begin
      lfsr_ff <= {lfsr_ff[5:0], lfsr_ff[6] ^ lfsr_ff[5]};
    end
  end
  // User flop behind the tap adds one more stage
  always_ff @(posedge clk) begin
    tap_late_ff <= tap_bit;
  end
  assign tap_late  = tap_late_ff;
  assign serial_in = lfsr_ff[0];
  assign chain_in  = ~lfsr_ff[0];
  assign tap_ready = ~stall;
endmodule // lsr_user_model

// ---- verif/tb_top.sv ----
// ==========================================================
// Testbench
module tb_top;
  import lsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, nrst = 0, en = 1, shift_en = 0, stall = 0;
  logic [15:0] tap_addr = 16'h0000;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h0;
  logic        avs_read = 0, avs_write = 0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, x;
  logic        serial_in, chain_in, tap_ready, chain_out, tap_valid;
  logic        avs_waitrequest, en_used = 0, tap_late;
  logic [3:0]  tap_out, last_stage_out, tap_data;
  logic        hist[$];
  int          n_errors = 0, n_tests = 0, fill = 0;
  always #25 clk = ~clk;
  lsr_user_model lsr_user_model_inst (.clk(clk), .nrst(nrst),
    .stall(stall), .tap_bit(tap_out[0]), .serial_in(serial_in),
    .chain_in(chain_in), .tap_ready(tap_ready), .tap_late(tap_late));
  lsr_delay_line lsr_delay_line_inst (.clk(clk), .nrst(nrst), .en(en),
    .serial_in(serial_in), .chain_in(chain_in), .shift_en(shift_en),
    .tap_addr(tap_addr), .tap_out(tap_out),
    .last_stage_out(last_stage_out), .chain_out(chain_out),
    .tap_valid(tap_valid), .tap_data(tap_data), .tap_ready(tap_ready),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // Own record of every bit shifted in; a full buffer stalls shifting
  always @(posedge clk) begin
    if (!stall) fill = 0;
    if (en && (shift_en || !en_used) && fill < 8) begin
      hist.push_front(serial_in);
      if (stall) fill++;
    end
  end
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic check_taps(input logic inv);
    logic [3:0] et, el;
    for (int n = 0; n < 16; n++) begin
      @(posedge clk);
      tap_addr <= {4{n[3:0]}};
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int e = 0; e < 4; e++) begin
        et[e] = hist[16*e+n] ^ inv;
        el[e] = hist[16*e+15] ^ inv;
      end
      chk("tap_out", 32'(et), 32'(tap_out));
      chk("last", 32'(el), 32'(last_stage_out));
      chk("chain_out", 32'(hist[63] ^ inv), 32'(chain_out));
      chk("tap_late", 32'(hist[n+1] ^ inv), 32'(tap_late));
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    bus(0, LSR_OFF_CTRL, 0, 0);
    chk("ctrl", 32'h00000e00, q);
    bus(0, 4'h2, 0, 0);
    chk("unmapped", 32'h0, q);
    tap_addr <= 16'h5a3c;
    bus(0, LSR_OFF_TAP, 0, 0);
    chk("tap reg", 32'h00005a3c, q);
    $display("test registers done");
    repeat (70) @(posedge clk);
    check_taps(1'b0);
    $display("test taps done");
    shift_en <= 1;
    bus(1, LSR_OFF_CTRL, 32'hffffff01, 4'h1);
    en_used = 1;
    shift_en <= 0;
    bus(0, LSR_OFF_CTRL, 0, 0);
    chk("ctrl", 32'h00000e01, q);
    repeat (12) @(posedge clk);
    bus(0, LSR_OFF_STAGES, 0, 0);
    for (int i = 0; i < 32; i++) x[i] = hist[i];
    chk("stages", x, q);
    shift_en <= 1;
    en <= 0;
    repeat (3) @(posedge clk);
    en <= 1;
    shift_en <= 0;
    bus(0, LSR_OFF_STAGES, 0, 0);
    chk("stages held", x, q);
    $display("test enable done");
    stall <= 1;
    shift_en <= 1;
    repeat (14) @(posedge clk);
    bus(0, LSR_OFF_STATUS, 0, 0);
    chk("status full", 32'h00030800, q & 32'h00030f00);
    for (int e = 0; e < 4; e++) x[e] = hist[16*e+22];
    chk("tap_data", 32'(x[3:0]), 32'(tap_data));
    stall <= 0;
    shift_en <= 0;
    repeat (12) @(posedge clk);
    bus(0, LSR_OFF_STATUS, 0, 0);
    chk("status empty", 32'h0, q & 32'h00030f00);
    shift_en <= 1;
    check_taps(1'b0);
    $display("test stall done");
    bus(1, LSR_OFF_CTRL, 32'h00000f00, 4'h2);
    repeat (70) @(posedge clk);
    check_taps(1'b1);
    $display("test chain in done");
    close_out;
  end
endmodule // tb_top
bind lsr_delay_line lsr_monitor #(.ELEMS(ELEMS)) lsr_monitor_inst (
  .clk, .nrst, .en, .avs_read, .avs_write, .avs_waitrequest,
  .avs_readdata, .tap_addr, .tap_out, .last_stage_out, .chain_out,
  .tap_valid, .tap_data, .tap_ready);
